// ### core/rmc_mode_ctrl.v
// Purpose: Retimer/redriver mode choice, CDR power, de-emphasis and output conditioning.
// Assumes: Pixel clock arrives as a sampled input; a divided copy (by 16) is measured.
// Notes:   Registers are reached over APB; every top output comes from a flip-flop.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_regs.vh"

module rmc_mode_ctrl #(
    parameter ACQ_CYCLES   = (`RMC_ACQ_MS * 1000 * 1000) / `RMC_CLK_NS,
    parameter CDRON_CYCLES = (`RMC_CDR_ON_MS * 1000 * 1000) / `RMC_CLK_NS,
    parameter WIN_CYCLES   = (`RMC_FREQ_WIN_US * 1000) / `RMC_CLK_NS,
    parameter THRESH_EDGES = (`RMC_THRESH_MHZ * `RMC_FREQ_WIN_US) / 16
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        pixClkDiv,
    input  wire        deemphPin,
    input  wire        outEnN,
    output reg         retimeOn,
    output reg         cdrPowerOn,
    output reg         cdrReady,
    output reg         pllForceLock,
    output reg         skewCompOn,
    output reg  [1:0]  deemphLevel,
    output reg  [2:0]  swingLevel,
    output reg         polarityInvert,
    output reg         txHighZ,
    output reg  [3:0]  eqCentre
);

    // =================================================================
    // Reset release and input synchronisers
    reg        rstMeta_ff;
    reg        rstSync_ff;
    reg  [2:0] pixSync_ff;
    reg  [1:0] deSync_ff;
    reg  [1:0] oeSync_ff;
    wire       rstN = rstSync_ff;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pixSync_ff <= 3'h0;
            deSync_ff  <= 2'h0;
            oeSync_ff  <= 2'h3;
        end else begin
            pixSync_ff <= {pixSync_ff[1:0], pixClkDiv};
            deSync_ff  <= {deSync_ff[0], deemphPin};
            oeSync_ff  <= {oeSync_ff[0], outEnN};
        end
    end

    // Edge detector reads only synchronised stages 1 and 2.
    wire pixRise = pixSync_ff[1] & ~pixSync_ff[2];

    // =================================================================
    // Registers
    reg [7:0] modeReg_ff;
    reg [7:0] outReg_ff;
    reg [7:0] ctrlReg_ff;
    wire      wrEn = psel & penable & pwrite;
    wire      rdEn = psel & ~penable & ~pwrite;

    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    wire known = hit(paddr, `RMC_ADDR_MODE) | hit(paddr, `RMC_ADDR_OUTCTL) |
                 hit(paddr, `RMC_ADDR_CTRL) | hit(paddr, `RMC_ADDR_STATUS) |
                 hit(paddr, `RMC_ADDR_FREQ);

    // =================================================================
    // Frequency measurement
    reg [15:0] winCnt_ff;
    reg [15:0] edgeCnt_ff;
    reg [15:0] freqVal_ff;
    reg        fast_ff;
    reg        measValid_ff;
    reg        newFreq_ff;
    wire       winEnd = (winCnt_ff == WIN_CYCLES[15:0] - 16'h0001);
    // The last cycle of a window still counts its edge, so no edge is lost at the boundary.
    wire [15:0] edgeNow = edgeCnt_ff + {15'h0000, pixRise};

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            winCnt_ff    <= 16'h0000;
            edgeCnt_ff   <= 16'h0000;
            freqVal_ff   <= 16'h0000;
            fast_ff      <= 1'b0;
            measValid_ff <= 1'b0;
            newFreq_ff   <= 1'b0;
        end else begin
            newFreq_ff <= 1'b0;
            if (winEnd) begin
                winCnt_ff    <= 16'h0000;
                edgeCnt_ff   <= 16'h0000;
                freqVal_ff   <= edgeNow;
                measValid_ff <= 1'b1;
                if (!measValid_ff || (edgeNow > THRESH_EDGES[15:0]) != fast_ff) begin
                    newFreq_ff <= 1'b1;
                end
                fast_ff <= (edgeNow > THRESH_EDGES[15:0]);
            end else begin
                winCnt_ff <= winCnt_ff + 16'h0001;
                if (pixRise) begin
                    edgeCnt_ff <= edgeCnt_ff + 16'h0001;
                end
            end
        end
    end

    // =================================================================
    // Mode decision and acquisition
    localparam [2:0] ST_REDRV = 3'b001;
    localparam [2:0] ST_ACQ   = 3'b010;
    localparam [2:0] ST_RETIM = 3'b100;

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [23:0] acqCnt_ff;
    reg  [23:0] onCnt_ff;
    wire [1:0]  funcMode = modeReg_ff[`RMC_MODE_FUNC_LSB +: 2];
    reg         wantRetime;

    always @* begin
        if (funcMode == `RMC_FUNC_REDRIVER) begin
            wantRetime = 1'b0;
        end else if (funcMode == `RMC_FUNC_AUTO) begin
            wantRetime = fast_ff;
        end else begin
            wantRetime = 1'b1;
        end
    end

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_REDRV: begin
                if (wantRetime) begin
                    nxt_state = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (!wantRetime) begin
                    nxt_state = ST_REDRV;
                end else if (acqCnt_ff == ACQ_CYCLES[23:0] - 24'h000001) begin
                    nxt_state = ST_RETIM;
                end
            end
            ST_RETIM: begin
                if (!wantRetime) begin
                    nxt_state = ST_REDRV;
                end else if (newFreq_ff) begin
                    nxt_state = ST_ACQ;
                end
            end
            default: nxt_state = ST_REDRV;
        endcase
    end

    wire retimeNow = (nxt_state != ST_REDRV);

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_ff  <= ST_REDRV;
            acqCnt_ff <= 24'h000000;
            onCnt_ff  <= 24'h000000;
        end else begin
            state_ff  <= nxt_state;
            acqCnt_ff <= (nxt_state == ST_ACQ && state_ff == ST_ACQ) ?
                         acqCnt_ff + 24'h000001 : 24'h000000;
            if (!retimeNow) begin
                onCnt_ff <= 24'h000000;
            end else if (onCnt_ff != CDRON_CYCLES[23:0]) begin
                onCnt_ff <= onCnt_ff + 24'h000001;
            end
        end
    end

    // =================================================================
    // Outputs
    wire strapMode = ctrlReg_ff[`RMC_CTRL_STRAP_BIT];

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            retimeOn       <= 1'b0;
            cdrPowerOn     <= 1'b0;
            cdrReady       <= 1'b0;
            pllForceLock   <= 1'b0;
            skewCompOn     <= 1'b0;
            deemphLevel    <= `RMC_DEEMPH_0DB;
            swingLevel     <= 3'h0;
            polarityInvert <= 1'b0;
            txHighZ        <= 1'b1;
            eqCentre       <= `RMC_EQ_SINK_CODE;
        end else begin
            retimeOn     <= retimeNow;
            cdrPowerOn   <= retimeNow;
            skewCompOn   <= retimeNow;
            cdrReady     <= retimeNow && (nxt_state == ST_RETIM ||
                            onCnt_ff == CDRON_CYCLES[23:0]);
            pllForceLock <= retimeNow & ctrlReg_ff[`RMC_CTRL_FLOCK_BIT];
            if (!retimeNow) begin
                deemphLevel <= `RMC_DEEMPH_0DB;
            end else if (strapMode) begin
                deemphLevel <= deSync_ff[1] ? `RMC_DEEMPH_2DB : `RMC_DEEMPH_0DB;
            end else begin
                deemphLevel <= outReg_ff[1:0];
            end
            swingLevel     <= outReg_ff[`RMC_SWING_LSB +: 3];
            polarityInvert <= retimeNow & ctrlReg_ff[`RMC_CTRL_POL_BIT];
            txHighZ <= oeSync_ff[1] |
                       (ctrlReg_ff[`RMC_CTRL_OFFACQ_BIT] & (nxt_state == ST_ACQ));
            eqCentre <= modeReg_ff[`RMC_MODE_PLACE_BIT] ? `RMC_EQ_SINK_CODE
                                                         : `RMC_EQ_SRC_CODE;
        end
    end

    // =================================================================
    // APB slave: one wait-free access, unmapped addresses error.
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            modeReg_ff <= `RMC_MODE_RST;
            outReg_ff  <= `RMC_OUTCTL_RST;
            ctrlReg_ff <= `RMC_CTRL_RST;
            prdata     <= 32'h00000000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            if (wrEn && pready) begin
                if (hit(paddr, `RMC_ADDR_MODE)) begin
                    modeReg_ff <= pwdata[7:0];
                end else if (hit(paddr, `RMC_ADDR_OUTCTL)) begin
                    outReg_ff <= pwdata[7:0];
                end else if (hit(paddr, `RMC_ADDR_CTRL)) begin
                    ctrlReg_ff <= {4'h0, pwdata[3:0]};
                end
            end
            if (rdEn) begin
                if (hit(paddr, `RMC_ADDR_MODE)) begin
                    prdata <= {24'h000000, modeReg_ff};
                end else if (hit(paddr, `RMC_ADDR_OUTCTL)) begin
                    prdata <= {24'h000000, outReg_ff};
                end else if (hit(paddr, `RMC_ADDR_CTRL)) begin
                    prdata <= {24'h000000, ctrlReg_ff};
                end else if (hit(paddr, `RMC_ADDR_STATUS)) begin
                    prdata <= {27'h0000000, measValid_ff, fast_ff, state_ff == ST_ACQ,
                               cdrReady, retimeOn};
                end else if (hit(paddr, `RMC_ADDR_FREQ)) begin
                    prdata <= {16'h0000, freqVal_ff};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ### core/rmc_regs.vh
// Purpose: Register map, field layout and timing constants of the retimer mode control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses; register indices are kept for the printed offsets.
`ifndef RMC_REGS_VH
`define RMC_REGS_VH

// =====================================================================
// Register offsets
`define RMC_IDX_MODE        8'h0a
`define RMC_IDX_OUTCTL      8'h0c
`define RMC_ADDR_MODE       12'h028
`define RMC_ADDR_OUTCTL     12'h030
`define RMC_ADDR_CTRL       12'h040
`define RMC_ADDR_STATUS     12'h044
`define RMC_ADDR_FREQ       12'h048

// =====================================================================
// Fields and reset values
`define RMC_MODE_FUNC_LSB   0
`define RMC_MODE_PLACE_BIT  7
`define RMC_MODE_RST        8'h83
`define RMC_FUNC_REDRIVER   2'b00
`define RMC_FUNC_AUTO       2'b11
`define RMC_OUTCTL_RST      8'h00
`define RMC_DEEMPH_0DB      2'b00
`define RMC_DEEMPH_2DB      2'b01
`define RMC_SWING_LSB       5
`define RMC_CTRL_RST        8'h00
`define RMC_CTRL_STRAP_BIT  0
`define RMC_CTRL_OFFACQ_BIT 1
`define RMC_CTRL_POL_BIT    2
`define RMC_CTRL_FLOCK_BIT  3
`define RMC_EQ_SINK_CODE    4'hc
`define RMC_EQ_SRC_CODE     4'h7

// =====================================================================
// Timing
`define RMC_CLK_MHZ         10
`define RMC_ACQ_MS          7
`define RMC_CDR_ON_MS       15
`define RMC_CDR_OFF_NS      120
`define RMC_CLK_NS          100
`define RMC_FREQ_WIN_US     10
`define RMC_THRESH_MHZ      100

`endif

// ### test/rmc_mode_ctrl_props.sv
// Purpose: Port-level checks on the retimer mode control.
// Assumes: One ref_clk domain with resetn active low.
// Notes:   Bound to every instance of the mode control.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_regs.vh"
module rmc_mode_ctrl_props (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        outEnN,
    input wire logic        retimeOn,
    input wire logic        cdrPowerOn,
    input wire logic        cdrReady,
    input wire logic        skewCompOn,
    input wire logic [1:0]  deemphLevel,
    input wire logic [2:0]  swingLevel,
    input wire logic        polarityInvert,
    input wire logic        txHighZ,
    input wire logic [3:0]  eqCentre
);
    wire wrAcc = psel & penable & pready & pwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ======
    // Mode outputs
    AST_CDR_PWR: assert property (cdrPowerOn == retimeOn)
        else $error("cdr power not tied to retiming");
    AST_SKEW: assert property (skewCompOn == retimeOn)
        else $error("skew compensation not tied to retiming");
    AST_DEEMPH_OFF: assert property (!retimeOn |-> deemphLevel == 2'b00)
        else $error("de-emphasis active in redriver");
    AST_POL_OFF: assert property (!retimeOn |-> !polarityInvert)
        else $error("polarity inverted in redriver");
    AST_CDR_RDY: assert property (cdrReady |-> retimeOn && $past(retimeOn))
        else $error("cdr ready outside retiming");
    AST_CDR_OFF: assert property ($fell(retimeOn) |-> !cdrReady && !cdrPowerOn)
        else $error("cdr still on after leaving retiming");
    AST_HIGHZ: assert property (outEnN [*4] |-> txHighZ)
        else $error("outputs driven while disabled");
    AST_FORCE_RDRV: assert property (wrAcc && paddr == `RMC_ADDR_MODE && pwdata[1:0] == 2'b00
        |-> ##[1:3] !retimeOn) else $error("forced redriver not taken");
    // ======
    // Register driven settings
    AST_EQ: assert property (wrAcc && paddr == `RMC_ADDR_MODE
        |-> ##2 eqCentre == ($past(pwdata[7], 2) ? `RMC_EQ_SINK_CODE : `RMC_EQ_SRC_CODE))
        else $error("equalizer centre wrong");
    AST_SWING: assert property (wrAcc && paddr == `RMC_ADDR_OUTCTL
        |-> ##2 swingLevel == $past(pwdata[7:5], 2)) else $error("swing level wrong");
endmodule
bind rmc_mode_ctrl rmc_mode_ctrl_props u_rmc_mode_ctrl_props (.ref_clk, .resetn, .psel,
    .penable, .pwrite, .pready, .paddr, .pwdata, .outEnN, .retimeOn, .cdrPowerOn, .cdrReady,
    .skewCompOn, .deemphLevel, .swingLevel, .polarityInvert, .txHighZ, .eqCentre);
`default_nettype wire

// ### test/rmc_mode_ctrl_tb.sv
// Purpose: Self-checking bench for the retimer mode control.
// Assumes: Short acquisition counts and a threshold of 20 edges per window.
// Notes:   A 400 ns half period is slow, 200 ns is fast for that threshold.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_regs.vh"
module rmc_mode_ctrl_tb;
    logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, deemphPin = 1'b0, outEnN = 1'b0, run = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] halfNs = 16'd400;
    logic        pready, pslverr, pixClkDiv, retimeOn, cdrPowerOn, cdrReady;
    logic        pllForceLock, skewCompOn, polarityInvert, txHighZ;
    logic [1:0]  deemphLevel;
    logic [2:0]  swingLevel;
    logic [3:0]  eqCentre;
    logic [32:0] expQ[$];
    integer      seed, errors = 0, samplesChecked = 0, waited;
    rmc_mode_ctrl #(.ACQ_CYCLES(20), .CDRON_CYCLES(40), .WIN_CYCLES(100), .THRESH_EDGES(20))
        u_rmc_mode_ctrl (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pixClkDiv, .deemphPin, .outEnN, .retimeOn, .cdrPowerOn,
        .cdrReady, .pllForceLock, .skewCompOn, .deemphLevel, .swingLevel, .polarityInvert,
        .txHighZ, .eqCentre);
    rmc_pix_source u_rmc_pix_source (.run, .halfNs, .pixClkDiv);
    always #50 ref_clk = ~ref_clk;
    // ======
    // Checking and bus tasks
    task finish_test;
        $display("checks %0d errors %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk_rd(input logic [32:0] e, input logic [32:0] g);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("unexpected read expected %h seen %h", e, g);
        end
    endtask
    task chk_out(input string n, input logic [3:0] e, input logic [3:0] g);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_rd(expQ.size() > 0 ? expQ.pop_front() : 33'bx, {pslverr, prdata});
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("unexpected pready expected 1 seen timeout");
            finish_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_on(input int s, input logic v);
        waited = 0;
        while ((s == 0 ? retimeOn : cdrReady) !== v && waited < 2000) begin
            @(posedge ref_clk);
            waited++;
        end
        if (waited >= 2000) begin
            errors++;
            $display("unexpected wait expected %b seen timeout", v);
            finish_test;
        end
    endtask
    // ======
    // Main sequence
    initial begin
        seed = 32'h986d2752;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_out("eqCentre", 4'hc, eqCentre);
        rd(`RMC_ADDR_MODE, 33'h83);
        apb(1'b1, 12'h0fc, 32'hff);
        rd(12'h0fc, {1'b1, 32'h0});
        run <= 1'b1;
        apb(1'b1, `RMC_ADDR_OUTCTL, 32'h61);
        apb(1'b1, `RMC_ADDR_CTRL, 32'h0c);
        repeat (300) @(posedge ref_clk);
        chk_out("retimeOn", 4'h0, {3'b0, retimeOn});
        chk_out("deemph", 4'h0, {2'b0, deemphLevel});
        chk_out("polarity", 4'h0, {3'b0, polarityInvert});
        halfNs <= 16'd200;
        wait_on(0, 1'b1);
        @(posedge ref_clk);
        chk_out("cdrReady", 4'h0, {3'b0, cdrReady});
        chk_out("deemph", 4'h1, {2'b0, deemphLevel});
        chk_out("polarity", 4'h1, {3'b0, polarityInvert});
        chk_out("forceLock", 4'h1, {3'b0, pllForceLock});
        chk_out("swing", 4'h3, {1'b0, swingLevel});
        wait_on(1, 1'b1);
        chk_out("cdrWait", 4'h1, {3'b0, waited <= 40});
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            apb(1'b1, `RMC_ADDR_OUTCTL, {24'h0, r[7:0]});
            @(posedge ref_clk);
            chk_out("swing", {1'b0, r[7:5]}, {1'b0, swingLevel});
        end
        apb(1'b1, `RMC_ADDR_CTRL, 32'h01);
        for (int i = 0; i < 2; i++) begin
            deemphPin <= i[0];
            repeat (4) @(posedge ref_clk);
            chk_out("deemph", {3'b0, i[0]}, {2'b0, deemphLevel});
        end
        halfNs <= 16'd400;
        wait_on(0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `RMC_ADDR_MODE, 32'h80 | i);
            repeat (300) @(posedge ref_clk);
            chk_out("retimeOn", {3'b0, i == 1 || i == 2}, {3'b0, retimeOn});
        end
        halfNs <= 16'd200;
        apb(1'b1, `RMC_ADDR_MODE, 32'h80);
        repeat (300) @(posedge ref_clk);
        chk_out("retimeOn", 4'h0, {3'b0, retimeOn});
        apb(1'b1, `RMC_ADDR_CTRL, 32'h02);
        apb(1'b1, `RMC_ADDR_MODE, 32'h03);
        @(posedge ref_clk);
        chk_out("eqCentre", 4'h7, eqCentre);
        rd(`RMC_ADDR_MODE, 33'h03);
        wait_on(0, 1'b1);
        repeat (2) @(posedge ref_clk);
        chk_out("txHighZ", 4'h1, {3'b0, txHighZ});
        rd(`RMC_ADDR_STATUS, 33'h1d);
        wait_on(1, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk_out("txHighZ", 4'h0, {3'b0, txHighZ});
        rd(`RMC_ADDR_STATUS, 33'h1b);
        outEnN <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk_out("txHighZ", 4'h1, {3'b0, txHighZ});
        finish_test;
    end
endmodule
`default_nettype wire

// ### test/rmc_pix_source.sv
// Purpose: Upstream source model giving the divided pixel clock.
// Assumes: The bench picks the half period and when frames run.
// Notes:   The clock holds still between frames, as a real source does.
`timescale 1ns/1ns
`default_nettype none
module rmc_pix_source (
    input  wire logic        run,
    input  wire logic [15:0] halfNs,
    output var  logic        pixClkDiv
);
    // ======
    // Link clock
    initial pixClkDiv = 1'b0;
    always begin
        if (run) begin
            #(halfNs) pixClkDiv = ~pixClkDiv;
        end else begin
            #50;
        end
    end
endmodule
`default_nettype wire
